// ===== hdl/e3rs_consts.vh
// register map, field positions and reset values of the e3 receive status bank
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef E3RS_CONSTS_VH
`define E3RS_CONSTS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define E3RS_IDX_COND_STATUS      12'h024
`define E3RS_IDX_EXP_PAYLOAD      12'h122
`define E3RS_IDX_CNT_NZ_STATUS    12'h126
`define E3RS_IDX_COND_LATCHED     12'h128
`define E3RS_IDX_ERR_LATCHED      12'h12a

`define E3RS_ADDR_COND_STATUS     (`E3RS_IDX_COND_STATUS << 2)
`define E3RS_ADDR_EXP_PAYLOAD     (`E3RS_IDX_EXP_PAYLOAD << 2)
`define E3RS_ADDR_CNT_NZ_STATUS   (`E3RS_IDX_CNT_NZ_STATUS << 2)
`define E3RS_ADDR_COND_LATCHED    (`E3RS_IDX_COND_LATCHED << 2)
`define E3RS_ADDR_ERR_LATCHED     (`E3RS_IDX_ERR_LATCHED << 2)

// ==========================================================
// condition status / condition change latched bit positions
`define E3RS_BIT_TIMING           13
`define E3RS_BIT_UNSTABLE         12
`define E3RS_BIT_MISMATCH         11
`define E3RS_BIT_PT_CHANGE        10
`define E3RS_BIT_UA1              8
`define E3RS_BIT_GC               7
`define E3RS_BIT_NR               6
`define E3RS_BIT_ALIGN            5
`define E3RS_BIT_LOF              4
`define E3RS_BIT_RDI              3
`define E3RS_BIT_AIS              2
`define E3RS_BIT_OOF              1
`define E3RS_BIT_LOS              0

// ==========================================================
// counter status / error latched bit positions
`define E3RS_BIT_REI_EVENT        10
`define E3RS_BIT_PAR_EVENT        9
`define E3RS_BIT_FRM_EVENT        8
`define E3RS_BIT_REI_NZ           2
`define E3RS_BIT_PAR_NZ           1
`define E3RS_BIT_FRM_NZ           0

// expected payload type field, bits 3:1; bit 0 is stored only
`define E3RS_EXP_PT_LSB           1
`define E3RS_EXP_PT_MSB           3

// ==========================================================
// reset values and bus answers
`define E3RS_RST_EXP_PAYLOAD      4'h0
`define E3RS_RST_LATCHED          16'h0000
`define E3RS_RESP_OKAY            2'b00
`define E3RS_RESP_SLVERR          2'b10

`endif

// ===== hdl/e3rs_change_latch.v
// sticky change latch: one bit set on a change (or a rise) of a value
// assumes value is registered in the same clock domain
`timescale 1ns/1ps
`default_nettype none

module e3rs_change_latch #(
  parameter W         = 1,
  parameter RISE_ONLY = 0
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         rst,
  // watched value and software clear
  input  wire [W-1:0] value,
  input  wire         clear,
  // sticky flag
  output reg          latched
);

  reg [W-1:0] prev;
  reg         armed;
  wire        hit;

  // ==========================================================
  // change detection
  // armed keeps the first sample after reset from counting as a change
  assign hit = RISE_ONLY ? (|(value & ~prev)) : (value != prev);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev    <= {W{1'b0}};
      armed   <= 1'b0;
      latched <= 1'b0;
    end else begin
      prev    <= value;
      armed   <= 1'b1;
      latched <= (latched & ~clear) | (armed & hit);
    end
  end

endmodule

`default_nettype wire

// ===== hdl/e3rs_status_regs.v
// e3 g.832 receive status and latched status bank behind an axi4-lite slave
// assumes framer condition inputs and counters are synchronous to core_clk
//
// Operation
// - condition bit 12 shows payload type unstable
// - condition bit 11 shows received payload type differs from expected type
// - condition bit 8 shows unframed all-ones condition
// - condition bit 4 shows loss of frame
// - condition bit 3 shows received remote defect indication
// - condition bit 2 shows alarm indication signal
// - condition bit 1 shows out of frame
// - condition bit 0 follows the loss-of-signal input level
// - counter bit 2 is one while remote error counter is non-zero
// - counter bit 1 is one while parity error counter is non-zero
// - counter bit 0 is one while framing error counter is non-zero
// - latched bit 13 sets on any timing-source bit change
// - latched bit 12 sets only on rise of payload unstable
// - latched bit 11 sets only on rise of payload mismatch
// - latched bit 10 sets on any received payload type change
// - latched bit 8 sets on any change of unframed all-ones
// - latched bits 7 and 6 set on gc and nr byte changes
// - latched bit 5 sets when a different frame alignment is loaded
// - latched bits 4..0 set on any change of their condition bits
// - error latched bits 10..8 set on remote, parity, framing error events
// - error latched bits 2..0 set on rise of counter non-zero bits
`timescale 1ns/1ps
`default_nettype none
`include "e3rs_consts.vh"

module e3rs_status_regs #(
  parameter ADDR_W = 12,
  parameter CNT_W  = 16
) (
  // clock and reset
  input  wire              core_clk,
  input  wire              rst,
  // framer conditions
  input  wire              payload_type_unstable,
  input  wire              unframed_all_ones,
  input  wire              frame_loss,
  input  wire              remote_defect,
  input  wire              alarm_signal,
  input  wire              out_of_frame,
  input  wire              rx_signal_loss_input,
  // extracted overhead values
  input  wire [2:0]        received_payload_type,
  input  wire [3:0]        timing_source_bits,
  input  wire [7:0]        received_general_comm_byte,
  input  wire [7:0]        received_network_req_byte,
  // framer event pulses
  input  wire              alignment_changed,
  input  wire              remote_err_event,
  input  wire              parity_err_event,
  input  wire              framing_err_event,
  // error counters
  input  wire [CNT_W-1:0]  remote_err_count,
  input  wire [CNT_W-1:0]  parity_err_count,
  input  wire [CNT_W-1:0]  framing_err_count,
  // axi4-lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready
);

  // ==========================================================
  // registered status
  reg        st_unstable;
  reg        st_mismatch;
  reg        st_ua1;
  reg        st_lof;
  reg        st_rdi;
  reg        st_ais;
  reg        st_oof;
  reg        st_los;
  reg  [2:0] st_ptype;
  reg  [3:0] st_tsrc;
  reg  [7:0] st_gc;
  reg  [7:0] st_nr;
  reg  [2:0] st_cnt_nz;
  reg  [3:0] exp_payload;

  // latched bits
  wire       lt_timing;
  wire       lt_unstable;
  wire       lt_mismatch;
  wire       lt_pt_change;
  wire       lt_ua1;
  wire       lt_gc;
  wire       lt_nr;
  reg        lt_align;
  wire [4:0] lt_cond;
  reg  [2:0] lt_err_event;
  wire [2:0] lt_cnt_rise;

  // bus state
  reg  [ADDR_W-1:0] wr_addr;
  reg  [31:0]       wr_data;
  reg  [3:0]        wr_strb;
  wire              wr_go;
  reg  [15:0]       clr_mask;
  reg  [15:0]       clr_cond;
  reg  [15:0]       clr_err;
  reg               wr_ok;
  reg               wr_exp;
  reg  [15:0]       rd_word;
  reg               rd_ok;
  wire [15:0]       cond_word;
  wire [15:0]       cnt_word;
  wire [15:0]       cond_latched_word;
  wire [15:0]       err_latched_word;

  // ==========================================================
  // status capture
  // one register stage so every status bit and its change latch see the same value
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_unstable <= 1'b0;
      st_mismatch <= 1'b0;
      st_ua1      <= 1'b0;
      st_lof      <= 1'b0;
      st_rdi      <= 1'b0;
      st_ais      <= 1'b0;
      st_oof      <= 1'b0;
      st_los      <= 1'b0;
      st_ptype    <= 3'h0;
      st_tsrc     <= 4'h0;
      st_gc       <= 8'h00;
      st_nr       <= 8'h00;
      st_cnt_nz   <= 3'h0;
    end else begin
      st_unstable <= payload_type_unstable;
      st_mismatch <= received_payload_type != exp_payload[`E3RS_EXP_PT_MSB:`E3RS_EXP_PT_LSB];
      st_ua1      <= unframed_all_ones;
      st_lof      <= frame_loss;
      st_rdi      <= remote_defect;
      st_ais      <= alarm_signal;
      st_oof      <= out_of_frame;
      st_los      <= rx_signal_loss_input;
      st_ptype    <= received_payload_type;
      st_tsrc     <= timing_source_bits;
      st_gc       <= received_general_comm_byte;
      st_nr       <= received_network_req_byte;
      st_cnt_nz[`E3RS_BIT_REI_NZ] <= |remote_err_count;
      st_cnt_nz[`E3RS_BIT_PAR_NZ] <= |parity_err_count;
      st_cnt_nz[`E3RS_BIT_FRM_NZ] <= |framing_err_count;
    end
  end

  // ==========================================================
  // change latches
  e3rs_change_latch #(.W(4), .RISE_ONLY(0)) u_timing (
    .core_clk (core_clk),
    .rst      (rst),
    .value    (st_tsrc),
    .clear    (clr_cond[`E3RS_BIT_TIMING]),
    .latched  (lt_timing)
  );

  e3rs_change_latch #(.W(1), .RISE_ONLY(1)) u_unstable (
    .core_clk (core_clk),
    .rst      (rst),
    .value    (st_unstable),
    .clear    (clr_cond[`E3RS_BIT_UNSTABLE]),
    .latched  (lt_unstable)
  );

  e3rs_change_latch #(.W(1), .RISE_ONLY(1)) u_mismatch (
    .core_clk (core_clk),
    .rst      (rst),
    .value    (st_mismatch),
    .clear    (clr_cond[`E3RS_BIT_MISMATCH]),
    .latched  (lt_mismatch)
  );

  e3rs_change_latch #(.W(3), .RISE_ONLY(0)) u_pt_change (
    .core_clk (core_clk),
    .rst      (rst),
    .value    (st_ptype),
    .clear    (clr_cond[`E3RS_BIT_PT_CHANGE]),
    .latched  (lt_pt_change)
  );

  e3rs_change_latch #(.W(1), .RISE_ONLY(0)) u_ua1 (
    .core_clk (core_clk),
    .rst      (rst),
    .value    (st_ua1),
    .clear    (clr_cond[`E3RS_BIT_UA1]),
    .latched  (lt_ua1)
  );

  e3rs_change_latch #(.W(8), .RISE_ONLY(0)) u_gc (
    .core_clk (core_clk),
    .rst      (rst),
    .value    (st_gc),
    .clear    (clr_cond[`E3RS_BIT_GC]),
    .latched  (lt_gc)
  );

  e3rs_change_latch #(.W(8), .RISE_ONLY(0)) u_nr (
    .core_clk (core_clk),
    .rst      (rst),
    .value    (st_nr),
    .clear    (clr_cond[`E3RS_BIT_NR]),
    .latched  (lt_nr)
  );

  // lof, rdi, ais, oof, los in bit order 4..0
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_cond
      e3rs_change_latch #(.W(1), .RISE_ONLY(0)) u_cond (
        .core_clk (core_clk),
        .rst      (rst),
        .value    (cond_word[gi]),
        .clear    (clr_cond[gi]),
        .latched  (lt_cond[gi])
      );
    end
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cnt
      e3rs_change_latch #(.W(1), .RISE_ONLY(1)) u_cnt (
        .core_clk (core_clk),
        .rst      (rst),
        .value    (st_cnt_nz[gi]),
        .clear    (clr_err[gi]),
        .latched  (lt_cnt_rise[gi])
      );
    end
  endgenerate

  // event pulses latch directly; set wins over a same-cycle clear
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lt_align     <= 1'b0;
      lt_err_event <= 3'h0;
    end else begin
      lt_align <= (lt_align & ~clr_cond[`E3RS_BIT_ALIGN]) | alignment_changed;
      lt_err_event <= (lt_err_event & ~clr_err[`E3RS_BIT_REI_EVENT:`E3RS_BIT_FRM_EVENT])
                      | {remote_err_event, parity_err_event, framing_err_event};
    end
  end

  // ==========================================================
  // register words
  assign cond_word = {3'h0, st_unstable, st_mismatch, 2'h0, st_ua1,
                      3'h0, st_lof, st_rdi, st_ais, st_oof, st_los};
  assign cnt_word  = {13'h0000, st_cnt_nz};
  assign cond_latched_word = {2'h0, lt_timing, lt_unstable, lt_mismatch, lt_pt_change, 1'b0, lt_ua1,
                              lt_gc, lt_nr, lt_align, lt_cond};
  assign err_latched_word  = {5'h00, lt_err_event, 5'h00, lt_cnt_rise};

  // ==========================================================
  // write path
  // address and data may arrive in either order; response follows both
  assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  always @* begin
    clr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & wr_data[15:0];
    clr_cond = `E3RS_RST_LATCHED;
    clr_err  = `E3RS_RST_LATCHED;
    wr_ok    = 1'b1;
    wr_exp   = 1'b0;
    if (wr_addr == `E3RS_ADDR_COND_LATCHED) begin
      clr_cond = wr_go ? clr_mask : `E3RS_RST_LATCHED;
    end else if (wr_addr == `E3RS_ADDR_ERR_LATCHED) begin
      clr_err = wr_go ? clr_mask : `E3RS_RST_LATCHED;
    end else if (wr_addr == `E3RS_ADDR_EXP_PAYLOAD) begin
      wr_exp = wr_go & wr_strb[0];
    end else if (wr_addr == `E3RS_ADDR_COND_STATUS) begin
      wr_ok = 1'b1;
    end else if (wr_addr == `E3RS_ADDR_CNT_NZ_STATUS) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `E3RS_RESP_OKAY;
      wr_addr       <= {ADDR_W{1'b0}};
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
      exp_payload   <= `E3RS_RST_EXP_PAYLOAD;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `E3RS_RESP_OKAY : `E3RS_RESP_SLVERR;
      end
      if (wr_exp) begin
        exp_payload <= wr_data[3:0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read path
  // reads never disturb the latches; clearing is by write only
  always @* begin
    rd_word = 16'h0000;
    rd_ok   = 1'b1;
    if (s_axi_araddr == `E3RS_ADDR_COND_STATUS) begin
      rd_word = cond_word;
    end else if (s_axi_araddr == `E3RS_ADDR_CNT_NZ_STATUS) begin
      rd_word = cnt_word;
    end else if (s_axi_araddr == `E3RS_ADDR_COND_LATCHED) begin
      rd_word = cond_latched_word;
    end else if (s_axi_araddr == `E3RS_ADDR_ERR_LATCHED) begin
      rd_word = err_latched_word;
    end else if (s_axi_araddr == `E3RS_ADDR_EXP_PAYLOAD) begin
      rd_word = {12'h000, exp_payload};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `E3RS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_word};
        s_axi_rresp   <= rd_ok ? `E3RS_RESP_OKAY : `E3RS_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== tb/e3rs_status_regs_assertions.sv
// checker for the receive status bank: bus handshakes and status views
// bound to e3rs_status_regs; sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "e3rs_consts.vh"

module e3rs_sr_chk #(
  parameter ADDR_W = 12,
  parameter CNT_W  = 16
) (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst,
  // watched framer inputs
  input wire logic              rx_signal_loss_input,
  input wire logic [CNT_W-1:0]  remote_err_count,
  input wire logic [CNT_W-1:0]  framing_err_count,
  // write channels
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  // read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire w_take  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire mapped  = s_axi_araddr inside {`E3RS_ADDR_COND_STATUS, `E3RS_ADDR_EXP_PAYLOAD,
    `E3RS_ADDR_CNT_NZ_STATUS, `E3RS_ADDR_COND_LATCHED, `E3RS_ADDR_ERR_LATCHED};

  // ==========================================================
  // bus handshakes
  wr_resp_a:
  // response flop loads one edge after both takes are registered
  assert property (w_take |=> ##1 s_axi_bvalid) else $error("write response late");
  b_hold_a:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  aw_block_a:
  assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("second write taken");
  rd_resp_a:
  assert property (ar_take |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  r_hold_a:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  r_done_a:
  assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid)
    else $error("read channel not freed");
  bad_addr_a:
  assert property (ar_take && !mapped |=> s_axi_rresp == `E3RS_RESP_SLVERR) else $error("unmapped read answered okay");

  // ==========================================================
  // status views; stable inputs make the check latency-free
  los_view_a:
  assert property (ar_take && s_axi_araddr == `E3RS_ADDR_COND_STATUS && $stable(rx_signal_loss_input)
    && !$past(rst) |=> s_axi_rdata[0] == $past(rx_signal_loss_input)) else $error("loss bit wrong");
  cnt_nz_a:
  assert property (ar_take && s_axi_araddr == `E3RS_ADDR_CNT_NZ_STATUS && $stable(remote_err_count)
    && $stable(framing_err_count) && !$past(rst) |=> s_axi_rdata[2] == ($past(remote_err_count) != 0)
    && s_axi_rdata[0] == ($past(framing_err_count) != 0)) else $error("count flag wrong");

  cover property (w_take ##2 s_axi_bvalid && s_axi_bready);
  cover property (ar_take && !mapped);
  cover property (ar_take && s_axi_araddr == `E3RS_ADDR_COND_STATUS && rx_signal_loss_input);
endmodule

bind e3rs_status_regs e3rs_sr_chk #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_chk (.*);

`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the receive status bank
// drives framer inputs and an axi4-lite master from core_clk
`timescale 1ns/1ps
`default_nettype none
`include "e3rs_consts.vh"

module tb_top;
  localparam logic [11:0] AS = `E3RS_ADDR_COND_STATUS;
  localparam logic [11:0] AE = `E3RS_ADDR_EXP_PAYLOAD;
  localparam logic [11:0] AC = `E3RS_ADDR_CNT_NZ_STATUS;
  localparam logic [11:0] AL = `E3RS_ADDR_COND_LATCHED;
  localparam logic [11:0] AR = `E3RS_ADDR_ERR_LATCHED;
  localparam logic [1:0]  OK = `E3RS_RESP_OKAY;
  localparam logic [1:0]  SE = `E3RS_RESP_SLVERR;

  // ==========================================================
  // stimulus and observed signals
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [6:0]  cd = 7'h00;
  logic [2:0]  ptype = 3'h0;
  logic [3:0]  tsrc = 4'h0;
  logic [7:0]  gc = 8'h00;
  logic [7:0]  nr = 8'h00;
  logic [3:0]  ev = 4'h0;
  logic [15:0] cr = 16'h0000;
  logic [15:0] cp = 16'h0000;
  logic [15:0] cf = 16'h0000;
  logic [11:0] aw = 12'h000;
  logic [11:0] ar = 12'h000;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        br = 1'b0;
  logic        arv = 1'b0;
  logic        rr = 1'b0;
  logic        awr;
  logic        wr_r;
  logic        bv;
  logic        arr;
  logic        rv;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdat;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;

  e3rs_status_regs DUT (
    .core_clk(core_clk), .rst(rst),
    .payload_type_unstable(cd[6]), .unframed_all_ones(cd[5]), .frame_loss(cd[4]),
    .remote_defect(cd[3]), .alarm_signal(cd[2]), .out_of_frame(cd[1]),
    .rx_signal_loss_input(cd[0]), .received_payload_type(ptype), .timing_source_bits(tsrc),
    .received_general_comm_byte(gc), .received_network_req_byte(nr),
    .alignment_changed(ev[3]), .remote_err_event(ev[2]), .parity_err_event(ev[1]),
    .framing_err_event(ev[0]), .remote_err_count(cr), .parity_err_count(cp), .framing_err_count(cf),
    .s_axi_awaddr(aw), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ar), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));

  initial forever #5 core_clk = ~core_clk;

  // whole run needs well under two hundred cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      stop_test();
    end
  end

  // ==========================================================
  // bus and compare tasks
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cmpr(input logic [1:0] e, input logic [1:0] g);
    cmp({30'h0, e}, {30'h0, g});
  endtask

  // p pulses the framing event in the cycle the clear lands
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er, input bit p = 0);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
      ev[0] <= p && awr && awv;
    end while (awv || wv);
    while (!bv) @(posedge core_clk);
    br <= 1'b0;
    cmpr(er, bresp);
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge core_clk); while (!arr);
    arv <= 1'b0;
    do @(posedge core_clk); while (!rv);
    d = rdat;
    r = rresp;
    rr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    cmp(e, d);
    cmpr(OK, r);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rchk(AS, 32'h0);
    rchk(AC, 32'h0);
    rchk(AL, 32'h0);
    rchk(AR, 32'h0);
    rchk(AE, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_set;
    cd <= 7'h7f;
    ptype <= 3'h5;
    tsrc <= 4'h9;
    gc <= 8'h3c;
    nr <= 8'hc3;
    cr <= 16'h0001;
    cp <= 16'hffff;
    cf <= 16'h0002;
    ev <= 4'hf;
    @(posedge core_clk);
    ev <= 4'h0;
    repeat (3) @(posedge core_clk);
    rchk(AS, 32'h191f);
    rchk(AC, 32'h7);
    rchk(AL, 32'h3dff);
    rchk(AR, 32'h707);
    $display("test set done");
  endtask

  // falls of unstable, mismatch and counts must not latch
  task automatic t_fall;
    wr(AL, 32'hffff, OK);
    wr(AR, 32'hffff, OK);
    rchk(AL, 32'h0);
    rchk(AR, 32'h0);
    cd[6] <= 1'b0;
    cr <= 16'h0;
    cp <= 16'h0;
    cf <= 16'h0;
    wr(AE, 32'ha, OK);
    repeat (3) @(posedge core_clk);
    rchk(AS, 32'h011f);
    rchk(AC, 32'h0);
    rchk(AL, 32'h0);
    rchk(AR, 32'h0);
    rchk(AE, 32'ha);
    $display("test fall done");
  endtask

  task automatic t_w1c;
    cd[0] <= 1'b0;
    cd[5] <= 1'b0;
    ptype <= 3'h4;
    repeat (3) @(posedge core_clk);
    rchk(AL, 32'h0d01);
    wr(AL, 32'h400, OK);
    rchk(AL, 32'h0901);
    wr(AL, 32'h901, OK);
    rchk(AL, 32'h0);
    $display("test w1c done");
  endtask

  task automatic t_refuse;
    logic [31:0] d;
    logic [1:0]  r;
    wr(AS, 32'hffff, OK);
    rchk(AS, 32'h081e);
    wr(12'h004, 32'hffff, SE);
    rd(12'h004, d, r);
    cmpr(SE, r);
    $display("test refuse done");
  endtask

  task automatic t_win;
    ev[0] <= 1'b1;
    @(posedge core_clk);
    ev[0] <= 1'b0;
    repeat (2) @(posedge core_clk);
    wr(AR, 32'h100, OK, 1'b1);
    rchk(AR, 32'h100);
    wr(AR, 32'h100, OK);
    rchk(AR, 32'h0);
    $display("test win done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_set();
    t_fall();
    t_w1c();
    t_refuse();
    t_win();
    stop_test();
  end
endmodule

`default_nettype wire
